// ---- hw/mdsu_core.sv ----
// Sequential arithmetic engine: one shift step or two quotient bits per cycle
//
// Local design decision: register access over APB.
`timescale 1ns/1ps
`include "mdsu_consts.svh"
module mdsu_core
(
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              ce,
    input  wire logic              start,
    input  wire mdsu_pkg::mdsu_op_type op,
    input  wire logic [31:0]       acc_in,
    input  wire logic [15:0]       opb_in,
    input  wire logic              dir_right,
    input  wire logic [4:0]        count_in,
    output logic                   busy,
    output logic                   done,
    output logic [31:0]            acc_out,
    output logic [15:0]            rem_out,
    output logic [4:0]             count_out,
    output logic                   ovf
);
    import mdsu_pkg::*;

    typedef struct packed {
        logic        busy;
        logic        done;
        logic [4:0]  cyc;
        logic [4:0]  steps;
        logic        norm;
        mdsu_op_type op;
        logic [31:0] acc;
        logic [15:0] opb;
        logic [16:0] rem;
        logic        dir;
        logic [4:0]  cnt;
        logic        ovf;
    } mdsu_core_st_type;

    mdsu_core_st_type st_r;
    mdsu_core_st_type st_nxt;

    always_comb begin
        logic [16:0] trial;
        logic [31:0] prod;
        trial = 17'h00000;
        prod = 32'h00000000;
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        if (start) begin
            st_nxt.busy = 1'b1;
            st_nxt.op = op;
            st_nxt.acc = acc_in;
            st_nxt.opb = opb_in;
            st_nxt.rem = 17'h00000;
            st_nxt.dir = dir_right;
            st_nxt.norm = (op == MDSU_OP_SHIFT) && (count_in == 5'h00);
            st_nxt.cnt = count_in;
            st_nxt.steps = 5'h00;
            st_nxt.ovf = 1'b0;
            unique case (op)
                MDSU_OP_MUL: st_nxt.cyc = 5'(`MDSU_CYC_MUL);
                MDSU_OP_DIV32: st_nxt.cyc = 5'(`MDSU_CYC_DIV32);
                MDSU_OP_DIV16: st_nxt.cyc = 5'(`MDSU_CYC_DIV16);
                default: st_nxt.cyc = st_nxt.norm ? 5'(`MDSU_CYC_NORM_BASE - 1) : 5'(`MDSU_CYC_SHIFT_BASE - 1);
            endcase
            if (op == MDSU_OP_DIV16) begin
                st_nxt.acc = {acc_in[15:0], 16'h0000};
            end
        end else if (st_r.busy) begin
            unique case (st_r.op)
                MDSU_OP_MUL: begin
                    if (st_r.cyc == 5'h01) begin
                        prod = st_r.acc[15:0] * st_r.opb;
                        st_nxt.acc = prod;
                        st_nxt.ovf = (prod > 32'h0000FFFF);
                    end
                end
                MDSU_OP_DIV32, MDSU_OP_DIV16: begin
                    // Restoring division, two quotient bits per cycle keeps counts in reach
                    if (st_r.cyc != 5'h01) begin
                        for (int i = 0; i < 2; i++) begin
                            trial = {st_nxt.rem[15:0], st_nxt.acc[31]};
                            st_nxt.acc = {st_nxt.acc[30:0], 1'b0};
                            if (trial >= {1'b0, st_r.opb}) begin
                                st_nxt.rem = trial - {1'b0, st_r.opb};
                                st_nxt.acc[0] = 1'b1;
                            end else begin
                                st_nxt.rem = trial;
                            end
                        end
                    end else begin
                        st_nxt.ovf = (st_r.opb == 16'h0000);
                        if (st_r.op == MDSU_OP_DIV16) begin
                            st_nxt.acc = {16'h0000, st_r.acc[15:0]};
                        end
                    end
                end
                default: begin
                    if (st_r.norm) begin
                        if (st_r.steps == 5'h00 && st_r.cyc == 5'h01 && st_r.acc[31]) begin
                            st_nxt.ovf = 1'b1;
                        end
                        if (!st_r.acc[31] && st_r.acc != 32'h00000000 && st_r.steps != 5'h1F
                            && st_r.cyc == 5'h00) begin
                            st_nxt.acc = {st_r.acc[30:0], 1'b0};
                            st_nxt.steps = st_r.steps + 5'h01;
                        end
                    end else if (st_r.cyc == 5'h00 && st_r.steps != st_r.cnt) begin
                        st_nxt.acc = st_r.dir ? {1'b0, st_r.acc[31:1]} : {st_r.acc[30:0], 1'b0};
                        st_nxt.steps = st_r.steps + 5'h01;
                    end
                end
            endcase
            if (st_r.cyc != 5'h00) begin
                st_nxt.cyc = st_r.cyc - 5'h01;
            end
            // Shift: one setup and one final cycle plus one per position gives 3..33; normalize one more setup
            if (st_r.op == MDSU_OP_SHIFT) begin
                if (st_r.cyc == 5'h01) begin
                    st_nxt.cyc = 5'h00;
                end else if (st_r.cyc == 5'h00) begin
                    if (st_r.norm ? (st_r.acc[31] || st_r.acc == 32'h00000000 || st_r.steps == 5'h1F)
                                  : (st_r.steps == st_r.cnt)) begin
                        st_nxt.busy = 1'b0;
                        st_nxt.done = 1'b1;
                        st_nxt.cnt = st_r.norm ? st_r.steps : st_r.cnt;
                    end
                end
            end else if (st_r.cyc == 5'h01) begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{busy: 1'b0, done: 1'b0, cyc: 5'h00, steps: 5'h00, norm: 1'b0, op: MDSU_OP_NONE,
                      acc: 32'h00000000, opb: 16'h0000, rem: 17'h00000, dir: 1'b0, cnt: 5'h00, ovf: 1'b0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign busy = st_r.busy;
    assign done = st_r.done;
    assign acc_out = st_r.acc;
    assign rem_out = st_r.rem[15:0];
    assign count_out = st_r.cnt;
    assign ovf = st_r.ovf;
endmodule

// ---- hw/mdsu_cpu.sv ----
// Far end: APB-commanded CPU access port issuing register reads and writes
`timescale 1ns/1ps
`include "mdsu_consts.svh"
module mdsu_cpu
(
    input  wire logic        clk,
    input  wire logic        rst_b,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    mdsu_if.cpu              bus
);
    import mdsu_pkg::*;

    typedef struct packed {
        logic [7:0]  addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
        logic        pend;
        logic [7:0]  rdata;
        logic        rvalid;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } mdsu_cpu_st_type;

    mdsu_cpu_st_type st_r;
    mdsu_cpu_st_type st_nxt;

    // ----------------------------------------------------------------
    // APB slave: one wait state, then register access issued as a pulse
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        st_nxt.wr = 1'b0;
        st_nxt.rd = 1'b0;
        st_nxt.pready = 1'b0;
        st_nxt.pslverr = 1'b0;
        // Unit answers one cycle after the strobe
        if (st_r.pend && !st_r.rd) begin
            st_nxt.rdata = bus.rdata;
            st_nxt.rvalid = 1'b1;
            st_nxt.pend = 1'b0;
        end
        if (psel && penable && !st_r.pready) begin
            st_nxt.pready = 1'b1;
            st_nxt.prdata = 32'h00000000;
            unique case (paddr)
                `MDSU_APB_CMD: begin
                    if (pwrite) begin
                        st_nxt.addr = pwdata[7:0];
                        // Operand order is software's job; this port only replays it
                        st_nxt.wr = pwdata[`MDSU_CMD_WRITE_BIT];
                        st_nxt.rd = pwdata[`MDSU_CMD_READ_BIT] & ~pwdata[`MDSU_CMD_WRITE_BIT];
                        st_nxt.pend = st_nxt.rd;
                        st_nxt.rvalid = st_nxt.rd ? 1'b0 : st_r.rvalid;
                    end else begin
                        st_nxt.prdata = {24'h000000, st_r.addr};
                    end
                end
                `MDSU_APB_WDATA: begin
                    if (pwrite) begin
                        st_nxt.wdata = pwdata[7:0];
                    end else begin
                        st_nxt.prdata = {24'h000000, st_r.wdata};
                    end
                end
                `MDSU_APB_STATUS: st_nxt.prdata = {30'h00000000, st_r.pend, st_r.rvalid};
                `MDSU_APB_RDATA: st_nxt.prdata = {24'h000000, st_r.rdata};
                default: st_nxt.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{addr: 8'h00, wdata: 8'h00, wr: 1'b0, rd: 1'b0, pend: 1'b0, rdata: 8'h00,
                      rvalid: 1'b0, prdata: 32'h00000000, pready: 1'b0, pslverr: 1'b0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign bus.addr = st_r.addr;
    assign bus.wdata = st_r.wdata;
    assign bus.wr_en = st_r.wr;
    assign bus.rd_en = st_r.rd;
    assign prdata = st_r.prdata;
    assign pready = st_r.pready;
    assign pslverr = st_r.pslverr;
endmodule

// ---- hw/mdsu_unit.sv ----
// Device end: operand registers, sequence tracking and error checking
`timescale 1ns/1ps
`include "mdsu_consts.svh"
module mdsu_unit
(
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ce,
    mdsu_if.unit      bus,
    output logic      busy,
    output logic      error_flag,
    output logic      overflow_flag
);
    import mdsu_pkg::*;

    typedef struct packed {
        logic [5:0][7:0] md;
        logic            dir;
        logic [4:0]      cnt;
        logic            err;
        logic            ovf;
        logic            mon;
        logic [5:0]      seen;
        logic [3:0]      nwr;
        mdsu_op_type     last_op;
        logic [7:0]      rdata;
    } mdsu_unit_st_type;

    mdsu_unit_st_type st_r;
    mdsu_unit_st_type st_nxt;

    logic              core_start;
    mdsu_op_type       core_op;
    logic              core_busy;
    logic              core_done;
    logic [31:0]       core_acc;
    logic [15:0]       core_rem;
    logic [4:0]        core_cnt;
    logic              core_ovf;

    function automatic logic is_md(input logic [7:0] a);
        is_md = (a >= `MDSU_ADDR_BYTE0) && (a <= `MDSU_ADDR_BYTE5);
    endfunction

    // ----------------------------------------------------------------
    // Write sequence decode and register update
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] idx;
        idx = 3'(bus.addr - `MDSU_ADDR_BYTE0);
        st_nxt = st_r;
        core_start = 1'b0;
        core_op = MDSU_OP_NONE;
        if (core_done) begin
            st_nxt.md[3:0] = core_acc;
            if (st_r.last_op == MDSU_OP_DIV32 || st_r.last_op == MDSU_OP_DIV16) begin
                st_nxt.md[5:4] = core_rem;
            end
            st_nxt.ovf = core_ovf;
            if (st_r.last_op == MDSU_OP_SHIFT) begin
                st_nxt.cnt = core_cnt;
            end
        end
        if (bus.wr_en && (is_md(bus.addr) || bus.addr == `MDSU_ADDR_CTRL)) begin
            if (core_busy) begin
                st_nxt.err = 1'b1;
            end
            if (bus.addr == `MDSU_ADDR_CTRL) begin
                st_nxt.dir = bus.wdata[`MDSU_BIT_DIR];
                st_nxt.cnt = bus.wdata[4:0];
                if (st_r.seen == 6'b001111) begin
                    core_start = 1'b1;
                    core_op = MDSU_OP_SHIFT;
                end
                st_nxt.seen = 6'h00;
            end else begin
                st_nxt.md[idx] = bus.wdata;
                if (idx == 3'h0) begin
                    st_nxt.seen = 6'h01;
                    st_nxt.mon = 1'b1;
                    st_nxt.nwr = 4'h1;
                end else begin
                    st_nxt.seen = st_r.seen | (6'h01 << idx);
                    st_nxt.nwr = st_r.nwr + 4'h1;
                end
                if (idx == 3'h5) begin
                    // Order of byte writes tells the operation apart
                    if (st_r.seen == 6'b011111 && st_r.nwr == 4'h5) begin
                        core_start = 1'b1;
                        core_op = MDSU_OP_DIV32;
                    end else if (st_r.seen == 6'b010011 && st_r.nwr == 4'h3) begin
                        core_start = 1'b1;
                        // Byte4 before byte1 means multiply, after means short divide
                        core_op = st_r.last_op == MDSU_OP_MUL ? MDSU_OP_MUL : MDSU_OP_DIV16;
                    end
                    st_nxt.seen = 6'h00;
                end
                if (idx == 3'h4) begin
                    st_nxt.last_op = st_r.seen == 6'b000001 ? MDSU_OP_MUL : MDSU_OP_DIV16;
                end
            end
        end
        if (core_start) begin
            st_nxt.last_op = core_op;
        end
        if (bus.rd_en) begin
            if (is_md(bus.addr)) begin
                st_nxt.rdata = st_nxt.md[idx];
                if (core_busy && st_r.mon) begin
                    st_nxt.err = 1'b1;
                end
                if (!core_busy && ((idx == 3'h3 && (st_r.last_op == MDSU_OP_MUL || st_r.last_op == MDSU_OP_SHIFT))
                    || (idx == 3'h5 && (st_r.last_op == MDSU_OP_DIV32 || st_r.last_op == MDSU_OP_DIV16)))) begin
                    st_nxt.mon = 1'b0;
                end
            end else if (bus.addr == `MDSU_ADDR_CTRL) begin
                st_nxt.rdata = {st_r.err, st_nxt.ovf, st_r.dir, st_nxt.cnt};
                // Error set in the same cycle survives the clear
                if (!(bus.wr_en && core_busy)) begin
                    st_nxt.err = 1'b0;
                end
            end else begin
                st_nxt.rdata = 8'h00;
            end
        end
    end

    mdsu_core u_core (
        .clk       (clk),
        .rst_b     (rst_b),
        .ce        (ce),
        .start     (core_start & ce),
        .op        (core_op),
        .acc_in    (st_nxt.md[3:0]),
        .opb_in    (st_nxt.md[5:4]),
        .dir_right (st_nxt.dir),
        .count_in  (st_nxt.cnt),
        .busy      (core_busy),
        .done      (core_done),
        .acc_out   (core_acc),
        .rem_out   (core_rem),
        .count_out (core_cnt),
        .ovf       (core_ovf)
    );

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_r <= '{last_op: MDSU_OP_NONE, rdata: `MDSU_REG_RESET, default: '0};
        end else if (ce) begin
            st_r <= st_nxt;
        end
    end

    assign bus.rdata = st_r.rdata;
    assign busy = core_busy;
    assign error_flag = st_r.err;
    assign overflow_flag = st_r.ovf;
endmodule

// ---- include/mdsu_consts.svh ----
// Constants for the multiply, divide and shift unit
// Notes on behaviour
// - Multiply operands written byte0, byte4, byte1, byte5
// - Multiply starts on byte5, done after 11 cycles
// - Product in byte0..byte3, read ascending
// - Divide takes 17 (32-bit) or 9 (16-bit)
// - Long divide writes byte0 to byte5 ascending
// - Short divide writes byte0, byte1, byte4, byte5
// - Quotient low bytes, remainder in byte5:byte4
// - Divide results end with read of byte5
// - Shift left or right by nonzero count
// - Shift takes 3 to 33 cycles
// - Normalize until top bit set, 3-34 cycles
// - Count zero normalizes; count reads shifts done
// - Shift starts by byte0..byte3 then control write
// - Monitoring on first byte0 write, off final read
// - Write during computation sets error, restarts; code restarts only on a write that completes a start sequence
// - Monitored read during computation sets error only
// - Error flag read-only, cleared by control read
// - Overflow on zero divide, big product, normalized
// - Clean operation clears overflow; not writable
`ifndef MDSU_CONSTS_SVH
`define MDSU_CONSTS_SVH

// ----------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------
`define MDSU_ADDR_BYTE0     8'hE9
`define MDSU_ADDR_BYTE5     8'hEE
`define MDSU_ADDR_CTRL      8'hEF

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define MDSU_BIT_ERROR      7
`define MDSU_BIT_OVERFLOW   6
`define MDSU_BIT_DIR        5
`define MDSU_REG_RESET      8'h00

// ----------------------------------------------------------------
// Timing in CPU cycles
// ----------------------------------------------------------------
`define MDSU_CYC_MUL        11
`define MDSU_CYC_DIV32      17
`define MDSU_CYC_DIV16      9
`define MDSU_CYC_SHIFT_BASE 2
`define MDSU_CYC_NORM_BASE  3

// ----------------------------------------------------------------
// Controller APB map
// ----------------------------------------------------------------
`define MDSU_APB_CMD        12'h000
`define MDSU_APB_WDATA      12'h004
`define MDSU_APB_STATUS     12'h008
`define MDSU_APB_RDATA      12'h00C
`define MDSU_CMD_WRITE_BIT  8
`define MDSU_CMD_READ_BIT   9

`endif

// ---- include/mdsu_if.sv ----
// Register access link between CPU side and the arithmetic unit
`timescale 1ns/1ps
interface mdsu_if;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport unit (input wr_en, input rd_en, input addr, input wdata, output rdata);
    modport cpu  (output wr_en, output rd_en, output addr, output wdata, input rdata);
endinterface

// ---- include/mdsu_pkg.sv ----
// Types shared by the multiply, divide and shift unit
package mdsu_pkg;

    typedef enum logic [4:0] {
        MDSU_OP_NONE  = 5'b00001,
        MDSU_OP_MUL   = 5'b00010,
        MDSU_OP_DIV32 = 5'b00100,
        MDSU_OP_DIV16 = 5'b01000,
        MDSU_OP_SHIFT = 5'b10000
    } mdsu_op_type;

    typedef enum logic [2:0] {
        MDSU_ST_IDLE = 3'b001,
        MDSU_ST_LOAD = 3'b010,
        MDSU_ST_BUSY = 3'b100
    } mdsu_state_type;

endpackage

// ---- test/mdsu_monitor.sv ----
// Checker on the link between the CPU end and the arithmetic unit
`timescale 1ns/1ps
`include "mdsu_consts.svh"
module mdsu_monitor (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [7:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       busy,
    input wire logic       error_flag,
    input wire logic       overflow_flag
);
    // ----------------------------------------------------------------
    // Helper state
    // ----------------------------------------------------------------
    logic [39:0] hist_r;
    logic [5:0]  run_r, exp_r, go_len;
    logic [2:0]  bad_r, crd_r, idle_r;
    logic        mon_r, div_r, clean_r, opr;
    // Normalize left out: its length depends on the data
    always_comb begin
        opr = addr != 8'hEF;
        go_len = 6'h00;
        if (wr_en && addr == 8'hEE && hist_r[23:0] == 24'hE9EDEA) go_len = 6'(`MDSU_CYC_MUL);
        if (wr_en && addr == 8'hEE && hist_r[39:0] == 40'hE9EAEBECED) go_len = 6'(`MDSU_CYC_DIV32);
        if (wr_en && addr == 8'hEE && hist_r[23:0] == 24'hE9EAED) go_len = 6'(`MDSU_CYC_DIV16);
        if (wr_en && addr == 8'hEF && hist_r[31:0] == 32'hE9EAEBEC && wdata[4:0] != 5'h00)
            go_len = 6'(`MDSU_CYC_SHIFT_BASE) + {1'b0, wdata[4:0]};
    end
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {hist_r, run_r, exp_r, bad_r, crd_r, idle_r, mon_r, div_r, clean_r} <= '0;
        end else begin
            run_r <= busy ? run_r + 6'h01 : 6'h00;
            idle_r <= busy ? 3'h0 : (idle_r == 3'h7 ? idle_r : idle_r + 3'h1);
            bad_r <= {bad_r[1:0], busy && (wr_en || (rd_en && mon_r && opr))};
            crd_r <= {crd_r[1:0], rd_en && !opr};
            if (wr_en) begin
                hist_r <= {hist_r[31:0], addr};
                exp_r <= go_len;
                clean_r <= !busy;
            end
            if (wr_en && go_len != 6'h00) div_r <= addr == 8'hEE && go_len != 6'(`MDSU_CYC_MUL);
            if (wr_en && addr == 8'hE9) mon_r <= 1'b1;
            else if (rd_en && addr == (div_r ? 8'hEE : 8'hEC)) mon_r <= 1'b0;
        end
    end
    // ----------------------------------------------------------------
    // Properties
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    sequence s_err_soon;
        ##[1:3] error_flag;
    endsequence
    chk_op_length: assert property ($fell(busy) && clean_r && exp_r != 6'h00 |-> run_r == exp_r)
        else $error("busy length differs from operation");
    chk_start_busy: assert property (wr_en && go_len != 6'h00 && !busy |-> ##[1:2] busy)
        else $error("operation did not start");
    chk_err_write: assert property (wr_en && busy |-> s_err_soon)
        else $error("write while busy left error clear");
    chk_err_read: assert property (rd_en && busy && mon_r && opr |-> s_err_soon)
        else $error("read while busy left error clear");
    chk_err_cause: assert property ($rose(error_flag) |-> bad_r != 3'h0)
        else $error("error set without cause");
    chk_err_clear: assert property ($fell(error_flag) |-> crd_r != 3'h0)
        else $error("error cleared without control read");
    chk_ovf_hold: assert property (!busy && idle_r >= 3'h4 |-> $stable(overflow_flag))
        else $error("overflow changed while idle");
    chk_wr_pulse: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
    chk_rd_pulse: assert property (rd_en |=> !rd_en)
        else $error("read strobe longer than one cycle");
    chk_rdata_hold: assert property (!rd_en |=> $stable(rdata))
        else $error("read data moved without read");
endmodule

// ---- test/mdsu_unit_bench.sv ----
// Self-checking bench joining the CPU end and the arithmetic unit
`timescale 1ns/1ps
`include "mdsu_consts.svh"
module mdsu_unit_bench;
    import mdsu_pkg::*;
    typedef struct packed {
        logic [1:0]  op;
        logic [31:0] a;
        logic [15:0] b;
        logic [7:0]  ctl;
        logic        ovf;
    } mdsu_row_type;
    logic         clk, rst_b, psel, penable, pwrite, pready, pslverr, se, busy, error_flag, overflow_flag;
    logic [11:0]  paddr;
    logic [31:0]  pwdata, prdata, q;
    logic [7:0]   d;
    int           fail_count, check_count, cyc;
    mdsu_row_type rows [9];
    mdsu_if link ();
    mdsu_cpu i_mdsu_cpu (.clk(clk), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(link.cpu));
    mdsu_unit i_mdsu_unit (.clk(clk), .rst_b(rst_b), .ce(1'b1), .bus(link.unit), .busy(busy),
        .error_flag(error_flag), .overflow_flag(overflow_flag));
    mdsu_monitor i_mdsu_monitor (.clk(clk), .rst_b(rst_b), .wr_en(link.wr_en), .rd_en(link.rd_en),
        .addr(link.addr), .wdata(link.wdata), .rdata(link.rdata), .busy(busy), .error_flag(error_flag),
        .overflow_flag(overflow_flag));
    // ----------------------------------------------------------------
    // Bus, check and finish tasks
    // ----------------------------------------------------------------
    task complete_run;
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] v);
        @(posedge clk);
        {psel, penable, pwrite, paddr, pwdata} <= {1'b1, 1'b0, w, a, v};
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        {q, se} = {prdata, pslverr};
        {psel, penable} <= 2'h0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        apb(1'b1, `MDSU_APB_WDATA, {24'h0, v});
        apb(1'b1, `MDSU_APB_CMD, {23'h0, 1'b1, a});
    endtask
    task rd(input logic [7:0] a);
        apb(1'b1, `MDSU_APB_CMD, {22'h0, 2'h2, a});
        do apb(1'b0, `MDSU_APB_STATUS, 32'h0); while (q[1:0] !== 2'h1);
        apb(1'b0, `MDSU_APB_RDATA, 32'h0);
        d = q[7:0];
    endtask
    task idle;
        repeat (3) @(posedge clk);
        while (busy !== 1'b0) @(posedge clk);
    endtask
    task load(input mdsu_row_type r);
        int          ord[$];
        logic [47:0] v;
        v = {r.b, r.a};
        case (r.op)
            2'h0: ord = {0, 4, 1, 5};
            2'h1: ord = {0, 1, 2, 3, 4, 5};
            2'h2: ord = {0, 1, 4, 5};
            default: ord = {0, 1, 2, 3};
        endcase
        foreach (ord[i]) wr(8'hE9 + 8'(ord[i]), v[8 * ord[i] +: 8]);
        if (r.op == 2'h3) wr(8'hEF, r.ctl);
    endtask
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task run(input mdsu_row_type r, input logic peek);
        logic [47:0] e;
        logic [4:0]  n;
        logic        dz;
        int          rk[$];
        e = {16'h0, r.a};
        n = r.ctl[4:0];
        dz = r.ovf && (r.op == 2'h1 || r.op == 2'h2);
        rk = {0, 1, 2, 3};
        if (r.op == 2'h0) e[31:0] = r.a[15:0] * r.b;
        if (r.op == 2'h1) rk = {0, 1, 2, 3, 4, 5};
        if (r.op == 2'h2) rk = {0, 1, 4, 5};
        if ((r.op == 2'h1 || r.op == 2'h2) && !dz) e = {16'(e[31:0] % r.b), e[31:0] / r.b};
        if (r.op == 2'h3 && n != 5'h0) e[31:0] = r.ctl[5] ? r.a >> n : r.a << n;
        while (r.op == 2'h3 && r.ctl[4:0] == 5'h0 && e[31:0] != 32'h0 && !e[31]) begin
            e[31:0] = e[31:0] << 1;
            n = n + 5'h1;
        end
        load(r);
        if (peek) rd(8'hE9);
        idle();
        foreach (rk[i]) begin
            rd(8'hE9 + 8'(rk[i]));
            if (!dz) chk(d, e[8 * rk[i] +: 8]);
        end
        chk({6'h0, error_flag, overflow_flag}, {6'h0, peek, r.ovf});
        rd(8'hEF);
        chk(d & (r.op == 2'h3 ? 8'hFF : 8'hC0), {peek, r.ovf, r.op == 2'h3 ? {r.ctl[5], n} : 6'h0});
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            complete_run();
        end
    end
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        rst_b = 1'b0;
        rows = '{'{2'h0, 32'h0000_00FF, 16'h0100, 8'h00, 1'b0}, '{2'h0, 32'h0000_FFFF, 16'hFFFF, 8'h00, 1'b1},
            '{2'h1, 32'h1234_5678, 16'h1234, 8'h00, 1'b0}, '{2'h2, 32'h0000_FFFF, 16'h0007, 8'h00, 1'b0},
            '{2'h2, 32'h0000_1234, 16'h0000, 8'h00, 1'b1}, '{2'h3, 32'h0000_1234, 16'h0000, 8'h10, 1'b0},
            '{2'h3, 32'h8000_0001, 16'h0000, 8'h21, 1'b0}, '{2'h3, 32'h0001_0000, 16'h0000, 8'h00, 1'b0},
            '{2'h3, 32'h8000_0000, 16'h0000, 8'h00, 1'b1}};
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        chk({5'h0, busy, error_flag, overflow_flag}, 8'h00);
        for (int k = 0; k < 7; k++) begin
            rd(8'hE9 + 8'(k));
            chk(d, 8'h00);
        end
        apb(1'b0, 12'h010, 32'h0);
        chk({7'h0, se}, 8'h01);
        $display("reset test done");
        foreach (rows[i]) begin
            run(rows[i], 1'b0);
            $display("row %0d done", i);
        end
        wr(8'hEF, 8'h80);
        rd(8'hEF);
        chk(d & 8'hC0, 8'h40);
        $display("flag write test done");
        run(mdsu_row_type'{2'h0, 32'h0000_0002, 16'h0003, 8'h00, 1'b0}, 1'b1);
        rd(8'hEF);
        chk({6'h0, error_flag, d[7]}, 8'h00);
        $display("busy read test done");
        load(rows[2]);
        wr(8'hE9, 8'h55);
        idle();
        chk({7'h0, error_flag}, 8'h01);
        rd(8'hEF);
        rd(8'hEF);
        chk(d & 8'h80, 8'h00);
        $display("busy write test done");
        complete_run();
    end
endmodule
